// [prog_exec_cmd_pkg.sv]
// types shared by the programming command responder and its memory port
package prog_exec_cmd_pkg;

	typedef enum logic [2:0] {
		NVM_CONFIG_WRITE = 3'h0,
		NVM_CONFIG_READ  = 3'h1,
		NVM_BULK_ERASE   = 3'h2,
		NVM_ROW_ERASE    = 3'h3,
		NVM_CODE_READ    = 3'h4
	} nvm_op_t;

	typedef struct packed {
		nvm_op_t     op;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [2:0]  region;
	} nvm_req_t;

	typedef struct packed {
		logic [3:0] opcode;
		logic [3:0] last_cmd;
		logic [7:0] query_or_error_byte;
	} rsp_hdr_t;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_GATHER = 7'b0000010,
		ST_EXEC   = 7'b0000100,
		ST_WAIT   = 7'b0001000,
		ST_REPLY0 = 7'b0010000,
		ST_REPLY1 = 7'b0100000,
		ST_SPARE  = 7'b1000000
	} state_t;

	typedef enum logic [5:0] {
		PH_CFG_WRITE  = 6'b000001,
		PH_CFG_VERIFY = 6'b000010,
		PH_BULK       = 6'b000100,
		PH_ROW_ERASE  = 6'b001000,
		PH_ROW_VERIFY = 6'b010000,
		PH_BLANK      = 6'b100000
	} phase_t;

endpackage : prog_exec_cmd_pkg

// [prog_exec_cmd_regs.svh]
// command codes, field positions and response constants of the responder
`ifndef PROG_EXEC_CMD_REGS_SVH
`define PROG_EXEC_CMD_REGS_SVH

`define OPC_CONFIG_WRITE   4'h6
`define OPC_BULK_ERASE     4'h7
`define OPC_ROW_ERASE      4'h9
`define OPC_BLANK_QUERY    4'hA
`define OPC_VERSION_QUERY  4'hB

`define LEN_CONFIG_WRITE   12'h004
`define LEN_BULK_ERASE     12'h002
`define LEN_ROW_ERASE      12'h003
`define LEN_BLANK_QUERY    12'h003
`define LEN_VERSION_QUERY  12'h001

`define RSP_PASS           4'h1
`define RSP_FAIL           4'h2
`define RSP_UNKNOWN        4'h3
`define RSP_LENGTH         16'h0002

`define QE_NO_ERROR        8'h00
`define QE_VERIFY_FAIL     8'h01
`define QE_OTHER_ERROR     8'h02
`define QE_BLANK           8'hF0
`define QE_NOT_BLANK       8'h0F

`define REGION_GENERAL     3'h0
`define REGION_GEN_VECTORS 3'h2
`define REGION_FULL_CHIP   3'h3
`define REGION_BOOT_GEN    3'h4
`define REGION_GEN_CONFIG  3'h5

`define OPC_MSB            15
`define OPC_LSB            12
`define LEN_MSB            11
`define LEN_LSB            0
`define ROWS_MSB           15
`define ROWS_LSB           8
`define ADDR_HI_MSB        7
`define ADDR_HI_LSB        0
`define REGION_MSB         2
`define REGION_LSB         0
`define DATA_LEN_MSB       11
`define DATA_LEN_LSB       0

`define ROW_STEP           24'h000040
`define ROW_ALIGN_MASK     24'h00003F
`define WORD_STEP          24'h000002
`define ROW_WORD_SHIFT     5
`define CODE_SPACE_TOP_HI  8'h80
`define MAX_CODE_CHECK     16'd49152
`define MAX_DATA_CHECK     12'd2048
`define ERASED_LOW         20'hFFFFF
`define BLANK_START        24'h000000

`endif

// [prog_exec_cmd_responder.sv]
// command interpreter that executes programming commands and frames replies
`timescale 1ns/1ps
`include "prog_exec_cmd_regs.svh"

module prog_exec_cmd_responder #(
	parameter logic [7:0] EXEC_VERSION = 8'h10 // arbitrary value
) (
	input  wire logic                       ref_clk,
	input  wire logic                       rst_b,
	input  wire logic                       cmd_valid,
	input  wire logic [15:0]                cmd_word,
	output wire logic                       cmd_ready,
	output wire logic                       rsp_valid,
	output      logic [15:0]                rsp_word,
	input  wire logic                       rsp_ready,
	output      logic                       nvm_req_valid,
	output      prog_exec_cmd_pkg::nvm_req_t nvm_req,
	input  wire logic                       nvm_done,
	input  wire logic [23:0]                nvm_rdata
);

	prog_exec_cmd_pkg::state_t   state_ff;
	prog_exec_cmd_pkg::phase_t   phase_ff;
	prog_exec_cmd_pkg::rsp_hdr_t hdr_ff;
	logic [3:0]                  opcode_ff;
	logic [11:0]                 length_ff;
	logic [11:0]                 remain_ff;
	logic [1:0]                  idx_ff;
	logic [15:0]                 words_ff [1:3];
	logic [7:0]                  rows_left_ff;
	logic [15:0]                 count_ff;
	logic [23:0]                 base_ff;
	logic                        hdr_loaded_ff;

	wire logic [23:0] cmd_addr = {words_ff[1][`ADDR_HI_MSB:`ADDR_HI_LSB],
	                              words_ff[2]};
	wire logic [2:0]  region   = words_ff[1][`REGION_MSB:`REGION_LSB];
	wire logic [7:0]  num_rows = words_ff[1][`ROWS_MSB:`ROWS_LSB];
	wire logic        take     = cmd_valid & cmd_ready;
	wire logic        give     = rsp_valid & rsp_ready;

	// header packing used by every completion path
	function automatic prog_exec_cmd_pkg::rsp_hdr_t make_hdr(
		input logic [3:0] op,
		input logic [3:0] cmd,
		input logic [7:0] qe
	);
		prog_exec_cmd_pkg::rsp_hdr_t h;
		h.opcode              = op;
		h.last_cmd            = cmd;
		h.query_or_error_byte = qe;
		return h;
	endfunction : make_hdr

	function automatic logic reserved_region(input logic [2:0] r);
		case (r)
			`REGION_GENERAL, `REGION_GEN_VECTORS, `REGION_FULL_CHIP,
			`REGION_BOOT_GEN, `REGION_GEN_CONFIG: reserved_region = 1'b0;
			default: reserved_region = 1'b1;
		endcase
	endfunction : reserved_region

	function automatic logic word_erased(input logic [23:0] w);
		word_erased = (w[19:0] == `ERASED_LOW) & (&w[23:20]);
	endfunction : word_erased

	assign cmd_ready = (state_ff == prog_exec_cmd_pkg::ST_IDLE) |
	                   (state_ff == prog_exec_cmd_pkg::ST_GATHER);
	// header is loaded on the first reply cycle and offered from the next one
	assign rsp_valid = ((state_ff == prog_exec_cmd_pkg::ST_REPLY0) &
	                    hdr_loaded_ff) |
	                   (state_ff == prog_exec_cmd_pkg::ST_REPLY1);

	// command header: opcode, length and the count of words still to come
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			opcode_ff <= 4'h0;
			length_ff <= 12'h000;
			remain_ff <= 12'h000;
		end else if (take) begin
			if (state_ff == prog_exec_cmd_pkg::ST_IDLE) begin
				opcode_ff <= cmd_word[`OPC_MSB:`OPC_LSB];
				length_ff <= cmd_word[`LEN_MSB:`LEN_LSB];
				remain_ff <= cmd_word[`LEN_MSB:`LEN_LSB] - 12'd1;
			end else begin
				remain_ff <= remain_ff - 12'd1;
			end
		end
	end

	// argument words; words past the third are absorbed and dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			idx_ff      <= 2'd1;
			words_ff[1] <= 16'h0000;
			words_ff[2] <= 16'h0000;
			words_ff[3] <= 16'h0000;
		end else if (take) begin
			if (state_ff == prog_exec_cmd_pkg::ST_IDLE) begin
				// stale arguments must not leak into a shorter command
				idx_ff      <= 2'd1;
				words_ff[1] <= 16'h0000;
				words_ff[2] <= 16'h0000;
				words_ff[3] <= 16'h0000;
			end else if (idx_ff != 2'd0) begin
				words_ff[idx_ff] <= cmd_word;
				idx_ff           <= (idx_ff == 2'd3) ? 2'd0 : idx_ff + 2'd1;
			end
		end
	end

	// reply word register: header on the first reply cycle, length on accept
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rsp_word <= 16'h0000;
		end else if (give) begin
			rsp_word <= `RSP_LENGTH;
		end else if (state_ff == prog_exec_cmd_pkg::ST_REPLY0) begin
			rsp_word <= hdr_ff;
		end
	end

	// offering the header before rsp_word holds it would hand over a stale
	// word, so the first reply cycle is spent loading it
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hdr_loaded_ff <= 1'b0;
		end else begin
			hdr_loaded_ff <= (state_ff == prog_exec_cmd_pkg::ST_REPLY0) & !give;
		end
	end

	// sequencing, memory requests and response framing
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_ff      <= prog_exec_cmd_pkg::ST_IDLE;
			phase_ff      <= prog_exec_cmd_pkg::PH_CFG_WRITE;
			hdr_ff        <= '0;
			nvm_req_valid <= 1'b0;
			nvm_req       <= '0;
			rows_left_ff  <= 8'h00;
			count_ff      <= 16'h0000;
			base_ff       <= 24'h000000;
		end else begin
			// request is a single-cycle pulse; its fields stand until done
			nvm_req_valid <= 1'b0;
			unique case (state_ff)
			prog_exec_cmd_pkg::ST_IDLE: begin
				if (take) begin
					if (cmd_word[`LEN_MSB:`LEN_LSB] > 12'd1)
						state_ff <= prog_exec_cmd_pkg::ST_GATHER;
					else
						state_ff <= prog_exec_cmd_pkg::ST_EXEC;
				end
			end
			prog_exec_cmd_pkg::ST_GATHER: begin
				if (take && remain_ff == 12'd1)
					state_ff <= prog_exec_cmd_pkg::ST_EXEC;
			end
			prog_exec_cmd_pkg::ST_EXEC: begin
				state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
				// bad length or field fails with other-error
				hdr_ff   <= make_hdr(`RSP_FAIL, opcode_ff, `QE_OTHER_ERROR);
				case (opcode_ff)
				`OPC_CONFIG_WRITE: begin
					if (length_ff == `LEN_CONFIG_WRITE) begin
						nvm_req_valid <= 1'b1;
						nvm_req.op    <= prog_exec_cmd_pkg::NVM_CONFIG_WRITE;
						nvm_req.addr  <= cmd_addr;
						nvm_req.wdata <= words_ff[3];
						phase_ff      <= prog_exec_cmd_pkg::PH_CFG_WRITE;
						state_ff      <= prog_exec_cmd_pkg::ST_WAIT;
					end
				end
				`OPC_BULK_ERASE: begin
					// reserved region leaves memory untouched
					if (length_ff == `LEN_BULK_ERASE &&
					    !reserved_region(region)) begin
						nvm_req_valid  <= 1'b1;
						nvm_req.op     <= prog_exec_cmd_pkg::NVM_BULK_ERASE;
						nvm_req.region <= region;
						phase_ff       <= prog_exec_cmd_pkg::PH_BULK;
						state_ff       <= prog_exec_cmd_pkg::ST_WAIT;
					end
				end
				`OPC_ROW_ERASE: begin
					// code space only, aligned base
					if (length_ff == `LEN_ROW_ERASE && num_rows != 8'h00 &&
					    (cmd_addr & `ROW_ALIGN_MASK) == 24'h000000 &&
					    cmd_addr[23:16] < `CODE_SPACE_TOP_HI) begin
						nvm_req_valid <= 1'b1;
						nvm_req.op    <= prog_exec_cmd_pkg::NVM_ROW_ERASE;
						nvm_req.addr  <= cmd_addr;
						base_ff       <= cmd_addr;
						rows_left_ff  <= num_rows;
						phase_ff      <= prog_exec_cmd_pkg::PH_ROW_ERASE;
						state_ff      <= prog_exec_cmd_pkg::ST_WAIT;
					end
				end
				`OPC_BLANK_QUERY: begin
					if (length_ff == `LEN_BLANK_QUERY &&
					    words_ff[1] <= `MAX_CODE_CHECK &&
					    words_ff[2][`DATA_LEN_MSB:`DATA_LEN_LSB] <=
					    `MAX_DATA_CHECK) begin
						// an empty range holds nothing that could be programmed
						if (words_ff[1] == 16'h0000) begin
							hdr_ff <= make_hdr(`RSP_PASS, opcode_ff, `QE_BLANK);
						end else begin
							// code reads only, from address 0
							nvm_req_valid <= 1'b1;
							nvm_req.op    <= prog_exec_cmd_pkg::NVM_CODE_READ;
							nvm_req.addr  <= `BLANK_START;
							count_ff      <= words_ff[1];
							phase_ff      <= prog_exec_cmd_pkg::PH_BLANK;
							state_ff      <= prog_exec_cmd_pkg::ST_WAIT;
						end
					end
				end
				`OPC_VERSION_QUERY: begin
					// a version query of length one passes with the version byte
					if (length_ff == `LEN_VERSION_QUERY)
						hdr_ff <= make_hdr(`RSP_PASS, opcode_ff, EXEC_VERSION);
				end
				default: begin
					// nothing executes for an unknown opcode
					hdr_ff <= make_hdr(`RSP_UNKNOWN, opcode_ff, `QE_NO_ERROR);
				end
				endcase
			end
			prog_exec_cmd_pkg::ST_WAIT: begin
				// a done pulse is only looked at while a request is outstanding
				if (nvm_done) begin
					unique case (phase_ff)
					prog_exec_cmd_pkg::PH_CFG_WRITE: begin
						// read the register back before reporting
						nvm_req_valid <= 1'b1;
						nvm_req.op    <= prog_exec_cmd_pkg::NVM_CONFIG_READ;
						phase_ff      <= prog_exec_cmd_pkg::PH_CFG_VERIFY;
					end
					prog_exec_cmd_pkg::PH_CFG_VERIFY: begin
						state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
						if (nvm_rdata[15:0] == nvm_req.wdata)
							hdr_ff <= make_hdr(`RSP_PASS, opcode_ff, `QE_NO_ERROR);
						else
							hdr_ff <= make_hdr(`RSP_FAIL, opcode_ff,
							                   `QE_VERIFY_FAIL);
					end
					prog_exec_cmd_pkg::PH_BULK: begin
						state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
						hdr_ff   <= make_hdr(`RSP_PASS, opcode_ff, `QE_NO_ERROR);
					end
					prog_exec_cmd_pkg::PH_ROW_ERASE: begin
						nvm_req_valid <= 1'b1;
						rows_left_ff  <= rows_left_ff - 8'h01;
						if (rows_left_ff == 8'h01) begin
							// all rows erased: read every word back
							nvm_req.op   <= prog_exec_cmd_pkg::NVM_CODE_READ;
							nvm_req.addr <= base_ff;
							// rows of 32 words each are read back
							count_ff     <= {3'b000, num_rows, 5'b00000};
							phase_ff     <= prog_exec_cmd_pkg::PH_ROW_VERIFY;
						end else begin
							nvm_req.addr <= nvm_req.addr + `ROW_STEP;
						end
					end
					prog_exec_cmd_pkg::PH_ROW_VERIFY: begin
						if (!word_erased(nvm_rdata)) begin
							state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
							hdr_ff   <= make_hdr(`RSP_FAIL, opcode_ff,
							                     `QE_OTHER_ERROR);
						end else if (count_ff == 16'h0001) begin
							state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
							hdr_ff   <= make_hdr(`RSP_PASS, opcode_ff, `QE_NO_ERROR);
						end else begin
							nvm_req_valid <= 1'b1;
							nvm_req.addr  <= nvm_req.addr + `WORD_STEP;
							count_ff      <= count_ff - 16'h0001;
						end
					end
					prog_exec_cmd_pkg::PH_BLANK: begin
						if (!(&nvm_rdata)) begin
							state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
							hdr_ff   <= make_hdr(`RSP_PASS, opcode_ff,
							                     `QE_NOT_BLANK);
						end else if (count_ff == 16'h0001) begin
							state_ff <= prog_exec_cmd_pkg::ST_REPLY0;
							hdr_ff   <= make_hdr(`RSP_PASS, opcode_ff,
							                     `QE_BLANK);
						end else begin
							nvm_req_valid <= 1'b1;
							nvm_req.addr  <= nvm_req.addr + `WORD_STEP;
							count_ff      <= count_ff - 16'h0001;
						end
					end
					endcase
				end
			end
			prog_exec_cmd_pkg::ST_REPLY0: begin
				// header word one, then length word
				if (give) begin
					state_ff <= prog_exec_cmd_pkg::ST_REPLY1;
				end
			end
			prog_exec_cmd_pkg::ST_REPLY1: begin
				// a new command is taken only once both words are gone
				if (give) begin
					state_ff <= prog_exec_cmd_pkg::ST_IDLE;
				end
			end
			default: begin
				state_ff <= prog_exec_cmd_pkg::ST_IDLE;
			end
			endcase
		end
	end

endmodule : prog_exec_cmd_responder

// [prog_exec_cmd_responder_properties.sv]
// assertions on the responder's command, reply and memory ports
`timescale 1ns/1ps
module prog_exec_cmd_checker #(
	parameter logic [7:0] EXEC_VERSION = 8'h10
) (
	input wire logic                        ref_clk,
	input wire logic                        rst_b,
	input wire logic                        cmd_valid,
	input wire logic [15:0]                 cmd_word,
	input wire logic                        cmd_ready,
	input wire logic                        rsp_valid,
	input wire logic [15:0]                 rsp_word,
	input wire logic                        rsp_ready,
	input wire logic                        nvm_req_valid,
	input wire prog_exec_cmd_pkg::nvm_req_t nvm_req
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic        second_ff;
	logic [11:0] rem_ff;
	logic [3:0]  op_ff;
	logic [11:0] len_ff;
	logic        known;
	assign known = op_ff inside {4'h6, 4'h7, 4'h9, 4'hA, 4'hB};
	// tracks the header word of the command and the word of the reply
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			second_ff <= 1'b0;
			rem_ff <= 12'h000;
		end else begin
			if (rsp_valid && rsp_ready) second_ff <= !second_ff;
			if (cmd_valid && cmd_ready) begin
				if (rem_ff == 12'h000) begin
					op_ff <= cmd_word[15:12];
					len_ff <= cmd_word[11:0];
					rem_ff <= (cmd_word[11:0] > 12'h001) ?
						cmd_word[11:0] - 12'h001 : 12'h000;
				end else begin
					rem_ff <= rem_ff - 12'h001;
				end
			end
		end
	end
	a_reply_holds: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_word))
		else $error("reply word changed before accept");
	a_busy_refuses: assert property (
		rsp_valid |-> !cmd_ready) else $error("command taken during reply");
	a_length_word: assert property (
		rsp_valid && second_ff |-> rsp_word == 16'h0002)
		else $error("bad reply length word");
	a_reply_opcode: assert property (
		rsp_valid && !second_ff |-> rsp_word[15:12] inside {4'h1, 4'h2, 4'h3})
		else $error("bad reply opcode");
	a_echo_cmd: assert property (
		rsp_valid && !second_ff |-> rsp_word[11:8] == op_ff)
		else $error("echoed command differs");
	a_unknown_reply: assert property (
		rsp_valid && !second_ff && !known |-> rsp_word[15:0] ==
		{4'h3, op_ff, 8'h00}) else $error("unknown command reply wrong");
	a_unknown_idle: assert property (
		nvm_req_valid |-> known) else $error("memory used by unknown command");
	a_version_byte: assert property (
		rsp_valid && !second_ff && op_ff == 4'hB && len_ff == 12'h001
		|-> rsp_word == {4'h1, 4'hB, EXEC_VERSION}) else $error("bad version");
	a_erase_region: assert property (
		nvm_req_valid && nvm_req.op == prog_exec_cmd_pkg::NVM_BULK_ERASE
		|-> nvm_req.region inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5})
		else $error("reserved erase region requested");
	a_row_base: assert property (
		nvm_req_valid && nvm_req.op == prog_exec_cmd_pkg::NVM_ROW_ERASE
		|-> nvm_req.addr[5:0] == 6'h00 && nvm_req.addr[23:16] < 8'h80)
		else $error("row erase base outside code rows");
endmodule : prog_exec_cmd_checker
bind prog_exec_cmd_responder prog_exec_cmd_checker #(
	.EXEC_VERSION(EXEC_VERSION)
) i_prog_exec_cmd_checker (.ref_clk(ref_clk), .rst_b(rst_b),
	.cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
	.rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_ready(rsp_ready),
	.nvm_req_valid(nvm_req_valid), .nvm_req(nvm_req));

// [prog_exec_cmd_responder_test.sv]
// self-checking bench for the programming command responder
`timescale 1ns/1ps
module prog_exec_cmd_responder_test;
	logic                        ref_clk, rst_b, cmd_valid, cmd_ready;
	logic                        rsp_valid, rsp_ready, nvm_req_valid;
	logic                        nvm_done, slow, cfg_flip, load_en;
	logic [15:0]                 cmd_word, rsp_word;
	logic [23:0]                 nvm_rdata, load_addr;
	prog_exec_cmd_pkg::nvm_req_t nvm_req;
	int                          failures, check_count;
	localparam logic [7:0] VER = 8'h23;
	prog_exec_cmd_responder #(.EXEC_VERSION(VER)) i_prog_exec_cmd_responder (
		.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_word(rsp_word), .rsp_ready(rsp_ready),
		.nvm_req_valid(nvm_req_valid), .nvm_req(nvm_req),
		.nvm_done(nvm_done), .nvm_rdata(nvm_rdata));
	prog_mem_model i_prog_mem_model (.ref_clk(ref_clk), .rst_b(rst_b),
		.nvm_req_valid(nvm_req_valid), .nvm_req(nvm_req), .slow(slow),
		.cfg_flip(cfg_flip), .load_en(load_en), .load_addr(load_addr),
		.nvm_done(nvm_done), .nvm_rdata(nvm_rdata));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task wrap_up;
		if (failures == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	task stuck(input string what);
		failures++;
		$display("Error %s expected 1 seen 0", what);
		wrap_up();
	endtask : stuck
	task check(input string what, input logic [15:0] exp, got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// offers every word and holds it until taken
	task send(input logic [15:0] q[$]);
		int n;
		foreach (q[i]) begin
			cmd_valid <= 1'b1;
			cmd_word <= q[i];
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (cmd_ready !== 1'b1 && n < 2000);
			if (n >= 2000) stuck("cmd_ready");
			@(posedge ref_clk);
		end
		cmd_valid <= 1'b0;
	endtask : send
	// stalls each reply word, then accepts it
	task cmd(input logic [15:0] q[$], input logic [15:0] w1);
		int n;
		send(q);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge ref_clk);
				n++;
			end while (rsp_valid !== 1'b1 && n < 5000);
			if (n >= 5000) stuck("rsp_valid");
			repeat (2) @(negedge ref_clk);
			check("rsp_word", k ? 16'h0002 : w1, rsp_word);
			@(posedge ref_clk);
			rsp_ready <= 1'b1;
			@(posedge ref_clk);
			rsp_ready <= 1'b0;
		end
	endtask : cmd
	task version_query;
		cmd('{16'hB001}, {4'h1, 4'hB, VER});
		cmd('{16'hB002, 16'h0000}, 16'h2B02);
	endtask : version_query
	task bulk_erase_regions;
		logic [2:0] r;
		for (int i = 0; i < 8; i++) begin
			r = i[2:0];
			slow <= r[0];
			cmd('{16'h7002, {13'h0, r}},
				r inside {3'h1, 3'h6, 3'h7} ? 16'h2702 : 16'h1700);
		end
	endtask : bulk_erase_regions
	task config_write;
		cmd('{16'h6004, 16'h00F8, 16'h0000, 16'hA55A},
			16'h1600);
		cfg_flip <= 1'b1;
		cmd('{16'h6004, 16'h00F8, 16'h0002, 16'h5AA5}, 16'h2601);
		cfg_flip <= 1'b0;
	endtask : config_write
	task blank_and_rows;
		cmd('{16'h7002, 16'h0003}, 16'h1700);
		load_en <= 1'b1;
		load_addr <= 24'h000010;
		@(posedge ref_clk);
		load_en <= 1'b0;
		cmd('{16'hA003, 16'h0008, 16'h0000}, 16'h1AF0);
		cmd('{16'hA003, 16'h0009, 16'h0000}, 16'h1A0F);
		cmd('{16'h9003, 16'h0100, 16'h0010}, 16'h2902);
		cmd('{16'h9003, 16'h0180, 16'h0000}, 16'h2902);
		cmd('{16'h9003, 16'h0100, 16'h0000}, 16'h1900);
		cmd('{16'hA003, 16'h0009, 16'h0000}, 16'h1AF0);
		cmd('{16'hA003, 16'hC001, 16'h0000}, 16'h2A02);
		cmd('{16'hA003, 16'h0001, 16'h0801}, 16'h2A02);
	endtask : blank_and_rows
	task unknown_opcodes;
		logic [3:0] ops[$];
		ops = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
		foreach (ops[i]) begin
			cmd('{{ops[i], 12'h001}}, {4'h3, ops[i], 8'h00});
		end
	endtask : unknown_opcodes
	// a reset in the middle of a slow erase drops it and leaves the port idle
	task reset_midway;
		slow <= 1'b1;
		send('{16'h7002, 16'h0003});
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		slow <= 1'b0;
		@(negedge ref_clk);
		check("cmd_ready", 16'h0001, {15'h0, cmd_ready});
		check("rsp_valid", 16'h0000, {15'h0, rsp_valid});
		check("nvm_req_valid", 16'h0000,
			{15'h0, nvm_req_valid});
		check("rsp_word", 16'h0000, rsp_word);
		@(posedge ref_clk);
		cmd('{16'hB001}, {4'h1, 4'hB, VER});
	endtask : reset_midway
	initial begin
		failures = 0;
		check_count = 0;
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
		rsp_ready = 1'b0;
		slow = 1'b0;
		cfg_flip = 1'b0;
		load_en = 1'b0;
		load_addr = 24'h000000;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		version_query();
		bulk_erase_regions();
		config_write();
		blank_and_rows();
		unknown_opcodes();
		reset_midway();
		wrap_up();
	end
endmodule : prog_exec_cmd_responder_test

// [prog_mem_model.sv]
// behavioural memory controller that answers the responder's requests
`timescale 1ns/1ps
module prog_mem_model (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	input  wire logic                        nvm_req_valid,
	input  wire prog_exec_cmd_pkg::nvm_req_t nvm_req,
	input  wire logic                        slow,
	input  wire logic                        cfg_flip,
	input  wire logic                        load_en,
	input  wire logic [23:0]                 load_addr,
	output      logic                        nvm_done,
	output      logic [23:0]                 nvm_rdata
);
	logic [23:0] code_mem [logic [23:0]];
	logic [15:0] cfg_mem [logic [23:0]];
	logic [23:0] rd_ff;
	int          wait_ff;
	// read data is only valid with done; otherwise it shows the inverse
	assign nvm_rdata = nvm_done ? rd_ff : ~rd_ff;
	always @(posedge ref_clk) begin
		nvm_done <= 1'b0;
		if (!rst_b) begin
			wait_ff <= 0;
		end else if (load_en) begin
			code_mem[load_addr] = 24'h123456;
		end else if (nvm_req_valid) begin
			wait_ff <= slow ? 6 : 1;
		end else if (wait_ff > 1) begin
			wait_ff <= wait_ff - 1;
		end else if (wait_ff == 1) begin
			wait_ff <= 0;
			nvm_done <= 1'b1;
			case (nvm_req.op)
			prog_exec_cmd_pkg::NVM_CONFIG_WRITE: begin
				cfg_mem[nvm_req.addr] = nvm_req.wdata;
			end
			prog_exec_cmd_pkg::NVM_CONFIG_READ: begin
				rd_ff <= {8'h00, cfg_mem[nvm_req.addr] ^ {15'h0, cfg_flip}};
			end
			prog_exec_cmd_pkg::NVM_BULK_ERASE: begin
				code_mem.delete();
			end
			prog_exec_cmd_pkg::NVM_ROW_ERASE: begin
				// code store only, config lives apart
				for (int i = 0; i < 32; i++) begin
					code_mem.delete(nvm_req.addr + 24'(2 * i));
				end
			end
			default: begin
				rd_ff <= code_mem.exists(nvm_req.addr) ?
					code_mem[nvm_req.addr] : 24'hFFFFFF;
			end
			endcase
		end
	end
endmodule : prog_mem_model
